// *** dv/caf_can_node.sv ***
// Behavioural CAN node model that hands received frames to the filter.
`timescale 1ns/1ps
module caf_can_node (
  input wire logic mclk,
  output logic rx_valid,
  output logic rx_ext,
  output logic rx_rtr,
  output logic [28:0] rx_id,
  output logic [7:0] rx_data0,
  output logic [7:0] rx_data1
);
  // ==========
  // Idle lines carry the inverse of the last frame, so stale data never looks valid.
  initial {rx_valid, rx_ext, rx_rtr, rx_id, rx_data0, rx_data1} = '0;
  task automatic send(input logic e, input logic r, input logic [28:0] id, input logic [15:0] d);
    @(posedge mclk);
    rx_valid <= 1'b1;
    {rx_ext, rx_rtr, rx_id, rx_data0, rx_data1} <= {e, r, id, d};
    @(posedge mclk);
    rx_valid <= 1'b0;
    {rx_ext, rx_rtr, rx_id, rx_data0, rx_data1} <= ~{e, r, id, d};
  endtask : send
endmodule : caf_can_node

// *** dv/caf_filter_checker.sv ***
// Checker of the frame output path of the CAN acceptance filter.
`timescale 1ns/1ps
module caf_filter_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic rx_ext,
  input wire logic rx_rtr,
  input wire logic [28:0] rx_id,
  input wire logic [7:0] rx_data0,
  input wire logic fwd_valid,
  input wire logic fwd_ext,
  input wire logic fwd_rtr,
  input wire logic [28:0] fwd_id,
  input wire logic [7:0] fwd_data0,
  input wire logic fwd_ts_valid,
  input wire logic [63:0] fwd_ts_ascii
);
  // ==========
  // Each forwarded frame is tied to the receive pulse one cycle before it.
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_acc;
    rx_valid ##1 fwd_valid;
  endsequence
  a_fwd_cause: assert property (fwd_valid |-> $past(rx_valid)) else $error("accept without frame");
  a_fwd_id: assert property (fwd_valid |-> fwd_id == $past(rx_id)) else $error("bad id");
  a_fwd_flags: assert property (s_acc |-> fwd_ext == $past(rx_ext) && fwd_rtr == $past(rx_rtr)) else $error("bad flags");
  a_fwd_data: assert property (fwd_valid && !fwd_ext |-> fwd_data0 == $past(rx_data0)) else $error("bad data");
  a_fwd_hold: assert property (!fwd_valid |-> $stable(fwd_id)) else $error("id moved");
  a_ts_only: assert property (fwd_ts_valid |-> fwd_valid) else $error("stray stamp");
  a_ts_hex_hi: assert property (fwd_ts_valid |-> fwd_ts_ascii[63:56] inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("bad top char");
  a_ts_hex_lo: assert property (fwd_ts_valid |-> fwd_ts_ascii[7:0] inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("bad low char");
endmodule : caf_filter_checker
bind caf_filter caf_filter_checker u_chk (.mclk, .resetn, .rx_valid, .rx_ext, .rx_rtr, .rx_id, .rx_data0,
  .fwd_valid, .fwd_ext, .fwd_rtr, .fwd_id, .fwd_data0, .fwd_ts_valid, .fwd_ts_ascii);

// *** dv/testbench.sv ***
// Self-checking testbench of the CAN acceptance filter.
`timescale 1ns/1ps
module testbench;
  // ==========
  // Bus, frame and bookkeeping signals; a short tick period keeps stamps moving.
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic tsen = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rv, t0;
  logic hreadyout, hresp, rx_valid, rx_ext, rx_rtr, fwd_valid, fwd_ext, fwd_rtr, fwd_ts_valid;
  logic [28:0] rx_id, fwd_id;
  logic [7:0] rx_data0, rx_data1, fwd_data0, fwd_data1;
  logic [63:0] fwd_ts_ascii;
  int miscompares = 0;
  int comparisons = 0;
  caf_filter #(.CYCLES_PER_US(2)) dut (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_valid, .rx_ext, .rx_rtr, .rx_id, .rx_data0, .rx_data1,
    .fwd_valid, .fwd_ext, .fwd_rtr, .fwd_id, .fwd_data0, .fwd_data1, .fwd_ts_valid, .fwd_ts_ascii);
  caf_can_node node (.mclk, .rx_valid, .rx_ext, .rx_rtr, .rx_id, .rx_data0, .rx_data1);
  always #2.5 mclk = ~mclk;
  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Waits a bounded number of edges for the slave to be ready.
  task automatic wait_ready;
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (hreadyout === 1'b1) return;
    end
    chk("hready", 1'b1, 1'b0);
    give_verdict;
  endtask : wait_ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    rv = hrdata;
    chk("hresp", 1'b0, hresp);
  endtask : xfer
  function automatic logic [63:0] enc(input logic [31:0] v);
    for (int i = 0; i < 8; i++) enc[8*i +: 8] = (v[4*i +: 4] < 4'hA) ? 8'h30 + v[4*i +: 4] : 8'h37 + v[4*i +: 4];
  endfunction : enc
  task automatic frame(input logic e, r, input logic [28:0] id, input logic [15:0] d, input logic acc);
    node.send(e, r, id, d);
    #1;
    chk("accept", acc, fwd_valid);
    chk("stamp flag", acc & tsen, fwd_ts_valid);
    if (acc) chk("fields", {e, r, id, e ? 16'h0 : d}, {fwd_ext, fwd_rtr, fwd_id, e ? 16'h0 : {fwd_data0, fwd_data1}});
  endtask : frame
  task automatic t_defaults;
    xfer(1'b0, caf_pkg::OFF_PATTERN, 32'h0);
    chk("pattern", 32'h0, rv);
    xfer(1'b0, caf_pkg::OFF_MASK, 32'h0);
    chk("mask", 32'hFFFF_FFFF, rv);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rv);
    frame(1'b1, 1'b1, 29'h15A5A5A5, 16'h0, 1'b1);
    $display("defaults done");
  endtask : t_defaults
  task automatic t_std;
    xfer(1'b1, caf_pkg::OFF_PATTERN, {11'h5A3, 1'b0, 4'h0, 16'hC33C});
    xfer(1'b1, caf_pkg::OFF_MASK, 32'h0);
    frame(1'b0, 1'b0, 29'h5A3, 16'hC33C, 1'b1);
    frame(1'b0, 1'b0, 29'h5A2, 16'hC33C, 1'b0);
    frame(1'b0, 1'b1, 29'h5A3, 16'hC33C, 1'b0);
    frame(1'b0, 1'b0, 29'h5A3, 16'hC23C, 1'b0);
    frame(1'b0, 1'b0, 29'h5A3, 16'hC3BC, 1'b0);
    xfer(1'b1, caf_pkg::OFF_MASK, 32'h0000_00FF);
    frame(1'b0, 1'b0, 29'h5A3, 16'hC3C3, 1'b1);
    $display("standard done");
  endtask : t_std
  task automatic t_ext;
    xfer(1'b1, caf_pkg::OFF_PATTERN, {29'h12345678, 1'b1, 2'h0});
    xfer(1'b1, caf_pkg::OFF_MASK, 32'h0);
    frame(1'b1, 1'b1, 29'h12345678, 16'hFFFF, 1'b1);
    frame(1'b1, 1'b0, 29'h12345678, 16'h0, 1'b0);
    frame(1'b1, 1'b1, 29'h02345678, 16'h0, 1'b0);
    xfer(1'b1, caf_pkg::OFF_MASK, 32'h0000_0004);
    frame(1'b1, 1'b0, 29'h12345678, 16'h0, 1'b1);
    $display("extended done");
  endtask : t_ext
  task automatic t_restore;
    xfer(1'b1, caf_pkg::OFF_CTRL, 32'h3);
    xfer(1'b0, caf_pkg::OFF_PATTERN, 32'h0);
    chk("pattern", 32'h0, rv);
    xfer(1'b0, caf_pkg::OFF_MASK, 32'h0);
    chk("mask", 32'hFFFF_FFFF, rv);
    xfer(1'b0, caf_pkg::OFF_CTRL, 32'h0);
    chk("stamp enable", 32'h0, rv);
    frame(1'b0, 1'b1, 29'h7FF, 16'h1234, 1'b1);
    xfer(1'b0, caf_pkg::OFF_STATUS, 32'h0);
    chk("status", 32'h3, rv);
    xfer(1'b0, caf_pkg::OFF_ACC_CNT, 32'h0);
    chk("accepted", 32'h6, rv);
    xfer(1'b0, caf_pkg::OFF_REJ_CNT, 32'h0);
    chk("rejected", 32'h6, rv);
    $display("restore done");
  endtask : t_restore
  task automatic t_stamp;
    logic hit;
    hit = 1'b0;
    tsen = 1'b1;
    xfer(1'b1, caf_pkg::OFF_CTRL, 32'h1);
    xfer(1'b0, caf_pkg::OFF_TICK, 32'h0);
    t0 = rv;
    frame(1'b0, 1'b0, 29'h001, 16'h0, 1'b1);
    for (int i = 0; i < 4; i++) hit |= (fwd_ts_ascii === enc(t0 + i));
    chk("stamp", 1'b1, hit);
    repeat (20) @(posedge mclk);
    xfer(1'b0, caf_pkg::OFF_TICK, 32'h0);
    chk("tick step", 1'b1, (rv - t0) inside {[32'h0000_000C:32'h0000_000D]});
    $display("stamp done");
  endtask : t_stamp
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    t_defaults;
    t_std;
    t_ext;
    t_restore;
    t_stamp;
    give_verdict;
  end
endmodule : testbench

// *** src/caf_filter.sv ***
// Top of the CAN receive acceptance filter with its AHB-Lite register slave.
`timescale 1ns/1ps
module caf_filter #(
  parameter int CYCLES_PER_US = caf_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_valid,
  input wire logic rx_ext,
  input wire logic rx_rtr,
  input wire logic [28:0] rx_id,
  input wire logic [7:0] rx_data0,
  input wire logic [7:0] rx_data1,
  output logic fwd_valid,
  output logic fwd_ext,
  output logic fwd_rtr,
  output logic [28:0] fwd_id,
  output logic [7:0] fwd_data0,
  output logic [7:0] fwd_data1,
  output logic fwd_ts_valid,
  output logic [63:0] fwd_ts_ascii
);
  // ==========================================================================
  // Declarations.
  logic [31:0] pattern_q;
  logic [31:0] mask_q;
  logic ts_en_q;
  logic [31:0] tick_us;
  logic [31:0] frame_bits;
  logic match;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic rd_sel;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic addr_ok;
  logic [1:0] last_q;
  logic [31:0] acc_cnt_q;
  logic [31:0] rej_cnt_q;
  logic defaults_wr;
  logic accept;
  logic [63:0] ts_ascii_d;
  logic [31:0] pattern_d;
  logic [31:0] mask_d;
  logic ts_en_d;
  logic [1:0] last_d;
  logic [31:0] acc_cnt_d;
  logic [31:0] rej_cnt_d;
  logic wr_pattern;
  logic wr_mask;
  logic wr_ctrl;
  logic [31:0] rd_word;
  logic [31:0] hrdata_q;

  // Converts one nibble into its hex ASCII character.
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    logic [7:0] base;
    base = (nib < 4'hA) ? caf_pkg::ASCII_ZERO : caf_pkg::ASCII_A_LESS10;
    return base + {4'h0, nib};
  endfunction : hex_char

  // Tells whether the pending write targets the register at the given offset.
  function automatic logic wr_hit(input logic pend, input logic [7:0] addr, input logic [7:0] off);
    return pend && (addr == off);
  endfunction : wr_hit

  // Spells the tick as eight hex characters, the most significant nibble in the top byte.
  function automatic logic [63:0] tick_to_ascii(input logic [31:0] tick);
    logic [63:0] text;
    text = 64'h0000_0000_0000_0000;
    for (int i = 0; i < 8; i++) begin
      text[i*8 +: 8] = hex_char(tick[i*4 +: 4]);
    end
    return text;
  endfunction : tick_to_ascii

  // ==========================================================================
  // Time tick.
  caf_tick #(.CYCLES_PER_US(CYCLES_PER_US)) u_tick (
    .mclk(mclk),
    .resetn(resetn),
    .tick_us(tick_us)
  );

  // ==========================================================================
  // Frame bits laid out like the pattern, a standard frame's data byte 0 in bits 15..8.
  assign frame_bits = rx_ext ? {rx_id[28:0], rx_rtr, 2'b00}
                             : {rx_id[10:0], rx_rtr, 4'h0, rx_data0, rx_data1};
  // Spare bits compare against a zero frame bit; keep the mask set there to ignore them.
  assign match = &(~(frame_bits ^ pattern_q) | mask_q);

  // Accepted-frame strobe and the time tag it would carry; the tick is taken in the receive cycle.
  assign accept = rx_valid && match;
  assign ts_ascii_d = tick_to_ascii(tick_us);

  // Output strobes, one cycle after the accepted frame.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fwd_valid <= 1'b0;
      fwd_ts_valid <= 1'b0;
    end else begin
      fwd_valid <= accept;
      fwd_ts_valid <= accept && ts_en_q;
    end
  end

  // Frame fields and time tag, held until the next accepted frame.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fwd_ext <= 1'b0;
      fwd_rtr <= 1'b0;
      fwd_id <= 29'h0000_0000;
      fwd_data0 <= 8'h00;
      fwd_data1 <= 8'h00;
      fwd_ts_ascii <= 64'h0000_0000_0000_0000;
    end else if (accept) begin
      fwd_ext <= rx_ext;
      fwd_rtr <= rx_rtr;
      fwd_id <= rx_id;
      fwd_data0 <= rx_data0;
      fwd_data1 <= rx_data1;
      fwd_ts_ascii <= ts_ascii_d;
    end
  end

  // Next values of the frame statistics; the counters wrap and are cleared only by reset.
  assign last_d = rx_valid ? {1'b1, match} : last_q;
  assign acc_cnt_d = acc_cnt_q + {31'h0000_0000, accept};
  assign rej_cnt_d = rej_cnt_q + {31'h0000_0000, rx_valid && !match};

  // Frame statistics for software.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      last_q <= 2'b00;
      acc_cnt_q <= 32'h0000_0000;
      rej_cnt_q <= 32'h0000_0000;
    end else begin
      last_q <= last_d;
      acc_cnt_q <= acc_cnt_d;
      rej_cnt_q <= rej_cnt_d;
    end
  end

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_sel = hsel && hready && htrans[1] && !hwrite;
  assign rd_addr = haddr[7:0];
  assign wr_pattern = wr_hit(wr_pend_q, wr_addr_q, caf_pkg::OFF_PATTERN);
  assign wr_mask = wr_hit(wr_pend_q, wr_addr_q, caf_pkg::OFF_MASK);
  assign wr_ctrl = wr_hit(wr_pend_q, wr_addr_q, caf_pkg::OFF_CTRL);
  assign defaults_wr = wr_ctrl && hwdata[caf_pkg::CTRL_DEFAULTS];

  // Address phase capture of writes; their data follow in the next cycle.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Next configuration; a defaults write beats every other field of the same write.
  assign pattern_d = defaults_wr ? caf_pkg::PATTERN_RST : (wr_pattern ? hwdata : pattern_q);
  assign mask_d = defaults_wr ? caf_pkg::MASK_RST : (wr_mask ? hwdata : mask_q);
  assign ts_en_d = defaults_wr ? 1'b0 : (wr_ctrl ? hwdata[caf_pkg::CTRL_TS_EN] : ts_en_q);

  // Configuration registers.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pattern_q <= caf_pkg::PATTERN_RST;
      mask_q <= caf_pkg::MASK_RST;
      ts_en_q <= 1'b0;
    end else begin
      pattern_q <= pattern_d;
      mask_q <= mask_d;
      ts_en_q <= ts_en_d;
    end
  end

  // Read mux over next values (the tick over its current count), so a read right behind a write or a frame sees its effect; unmapped reads give zero.
  assign addr_ok = (rd_addr <= caf_pkg::OFF_REJ_CNT) && (rd_addr[1:0] == 2'b00);
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      caf_pkg::OFF_PATTERN: rd_data = pattern_d;
      caf_pkg::OFF_MASK: rd_data = mask_d;
      caf_pkg::OFF_CTRL: rd_data = {31'h0000_0000, ts_en_d};
      caf_pkg::OFF_TICK: rd_data = tick_us;
      caf_pkg::OFF_STATUS: rd_data = {30'h0000_0000, last_d};
      caf_pkg::OFF_ACC_CNT: rd_data = acc_cnt_d;
      caf_pkg::OFF_REJ_CNT: rd_data = rej_cnt_d;
      default: rd_data = 32'h0000_0000;
    endcase
  end
  assign rd_word = addr_ok ? rd_data : 32'h0000_0000;

  // Read data register, loaded in the address phase so that it stands through the data phase.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_sel) begin
      hrdata_q <= rd_word;
    end
  end
  assign hrdata = hrdata_q;
endmodule : caf_filter

// *** src/caf_pkg.sv ***
// Package with register map, field layout and timing constants of the CAN receive acceptance filter.
package caf_pkg;
  // ==========================================================================
  // Register offsets (byte addresses).
  localparam logic [7:0] OFF_PATTERN = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_TICK = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_ACC_CNT = 8'h14;
  localparam logic [7:0] OFF_REJ_CNT = 8'h18;
  // ==========================================================================
  // Reset values.
  localparam logic [31:0] PATTERN_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'hFFFF_FFFF;
  // ==========================================================================
  // Control and status field positions.
  localparam int CTRL_TS_EN = 0;
  localparam int CTRL_DEFAULTS = 1;
  localparam int STAT_LAST_ACC = 0;
  localparam int STAT_LAST_VALID = 1;
  // ==========================================================================
  // Timing.
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  // ==========================================================================
  // Hex ASCII digit set.
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_A_LESS10 = 8'h37;
endpackage : caf_pkg

// *** src/caf_tick.sv ***
// Free-running microsecond time tick counter.
`timescale 1ns/1ps
module caf_tick #(
  parameter int CYCLES_PER_US = caf_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  output logic [31:0] tick_us
);
  // ==========================================================================
  // Prescaler and counter.
  logic [15:0] pre_q;
  logic [15:0] pre_d;
  logic us_pulse;
  logic [31:0] tick_q;
  logic [31:0] tick_d;

  // One-cycle enable each microsecond.
  assign us_pulse = (pre_q == 16'(CYCLES_PER_US - 1));
  assign pre_d = us_pulse ? 16'h0000 : pre_q + 16'h0001;
  assign tick_d = us_pulse ? tick_q + 32'h0000_0001 : tick_q;
  assign tick_us = tick_q;

  // Counter registers; the tick wraps naturally at its maximum.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 16'h0000;
      tick_q <= 32'h0000_0000;
    end else begin
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end
endmodule : caf_tick
